// ==== shared/hsh_params.svh ====
`ifndef HSH_PARAMS_SVH
`define HSH_PARAMS_SVH

// Homing method codes
`define HSH_METHOD_LEFT_FALL  4'h9
`define HSH_METHOD_RIGHT_FALL 4'hA

// Velocity word width
`define HSH_VEL_W 16

// Direction encoding
`define HSH_DIR_POS 1'b1
`define HSH_DIR_NEG 1'b0

// Search log depth and index width
`define HSH_LOG_DEPTH 8
`define HSH_LOG_AW    3

`endif

// ==== shared/hsh_pkg.sv ====
`default_nettype none
package hsh_pkg;
  // Gray codes along the usual path
  typedef enum logic [2:0] {
    HSH_IDLE     = 3'h0,
    HSH_SW_SRCH  = 3'h1,
    HSH_IDX_SRCH = 3'h3,
    HSH_DONE     = 3'h2,
    HSH_OT_SRCH  = 3'h6,
    HSH_REV_SRCH = 3'h7,
    HSH_FAULT    = 3'h5
  } hsh_state_t;
endpackage
`default_nettype wire

// ==== hw/hsh_phase_log.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "hsh_params.svh"
// Small memory recording the phase sequence of the last homing run
module hsh_phase_log
  import hsh_pkg::*;
(
  input  wire logic                      ref_clk_in,
  input  wire logic                      wr_en_in,
  input  wire logic [`HSH_LOG_AW-1:0]    wr_addr_in,
  input  wire logic [2:0]                wr_data_in,
  input  wire logic [`HSH_LOG_AW-1:0]    rd_addr_in,
  output logic      [2:0]                rd_data_out
);
  logic [2:0] mem [`HSH_LOG_DEPTH];

  // Write port
  always_ff @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read
  always_ff @(posedge ref_clk_in) begin
    rd_data_out <= mem[rd_addr_in];
  end
endmodule
`default_nettype wire

// ==== hw/hsh_homing.sv ====
// Contract
// R1: Method 10 homes on the index pulse right of the home switch falling edge, moving positive.
// R2: Method 10 starting outside the switch moves positive at near-home speed to the switch falling edge.
// R3: Method 10 after that edge moves positive at home-position speed to the next index and latches home.
// R4: Method 10 starting inside the switch also searches positive at near-home speed for the falling edge.
// R5: In the third start case of methods 9 and 10 the axis runs positive to overtravel, then negative for the switch rising edge.
// R6: Method 9 after the switch edge searches negative at home-position speed for the index left of it.
// R7: Method 9 overtravel case after the rising edge searches negative at home-position speed for the index.
// R8: Near-home speed serves all switch and limit phases, home-position speed only the index phase.
// R9: The first qualifying index of the final phase stops motion and signals homing complete.
`timescale 1ns/10ps
`default_nettype none
`include "hsh_params.svh"
module hsh_homing
  import hsh_pkg::*;
(
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_in,
  input  wire logic                      start_in,
  input  wire logic [3:0]                homing_method_select_in,
  input  wire logic                      third_case_in,
  input  wire logic [`HSH_VEL_W-1:0]     near_home_search_velocity_in,
  input  wire logic [`HSH_VEL_W-1:0]     home_position_search_velocity_in,
  input  wire logic                      home_switch_input_in,
  input  wire logic                      positive_overtravel_input_in,
  input  wire logic                      index_pulse_in,
  input  wire logic                      abort_in,
  input  wire logic [`HSH_LOG_AW-1:0]    log_addr_in,
  output logic                           move_en_out,
  output logic                           move_dir_out,
  output logic      [`HSH_VEL_W-1:0]     velocity_out,
  output logic                           busy_out,
  output logic                           home_done_out,
  output logic                           home_latch_out,
  output logic                           fault_out,
  output logic      [2:0]                log_data_out
);
  // Pin synchronisers, two stages each
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic       sw;
  logic       ot;
  logic       idx;
  logic       sw_d;
  logic       idx_d;
  logic       sw_fall;
  logic       sw_rise;
  logic       idx_rise;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
    end else begin
      sync1 <= {index_pulse_in, positive_overtravel_input_in, home_switch_input_in};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Edge detection on the synchronised levels
  always_comb begin
    sw       = sync2[0];
    ot       = sync2[1];
    idx      = sync2[2];
    sw_d     = sync3[0];
    idx_d    = sync3[2];
    sw_fall  = sw_d & ~sw;
    sw_rise  = ~sw_d & sw;
    idx_rise = ~idx_d & idx;
  end

  // Sequencer state
  hsh_state_t                state;
  hsh_state_t                next_state;
  logic [3:0]                method;
  logic [3:0]                next_method;
  logic                      next_move_en;
  logic                      next_move_dir;
  logic [`HSH_VEL_W-1:0]     next_velocity;
  logic                      next_busy;
  logic                      next_home_done;
  logic                      next_home_latch;
  logic                      next_fault;
  logic [`HSH_LOG_AW-1:0]    log_ptr;
  logic [`HSH_LOG_AW-1:0]    next_log_ptr;
  logic                      log_wr;

  // Only methods 9 and 10 are handled here
  function automatic logic method_ok(input logic [3:0] m);
    method_ok = (m == `HSH_METHOD_LEFT_FALL) || (m == `HSH_METHOD_RIGHT_FALL);
  endfunction

  // Index phase direction: right of switch is positive, left is negative
  function automatic logic index_dir(input logic [3:0] m);
    index_dir = (m == `HSH_METHOD_RIGHT_FALL) ? `HSH_DIR_POS : `HSH_DIR_NEG;
  endfunction

  always_comb begin
    next_state      = state;
    next_method     = method;
    next_move_en    = move_en_out;
    next_move_dir   = move_dir_out;
    next_velocity   = velocity_out;
    next_busy       = busy_out;
    next_home_done  = home_done_out;
    next_home_latch = 1'b0;
    next_fault      = fault_out;
    next_log_ptr    = log_ptr;
    log_wr          = 1'b0;
    if (abort_in && state != HSH_IDLE) begin
      next_state   = HSH_IDLE;
      next_move_en = 1'b0;
      next_busy    = 1'b0;
    end else begin
      case (state)
        HSH_IDLE: begin
          if (start_in) begin
            next_method    = homing_method_select_in;
            next_home_done = 1'b0;
            next_fault     = 1'b0;
            next_log_ptr   = '0;
            if (!method_ok(homing_method_select_in)) begin
              next_state = HSH_FAULT;
              next_fault = 1'b1;
            end else begin
              next_busy     = 1'b1;
              next_move_en  = 1'b1;
              next_move_dir = `HSH_DIR_POS;
              next_velocity = near_home_search_velocity_in; // R8
              if (third_case_in && !sw) begin
                next_state = HSH_OT_SRCH; // R5
              end else begin
                next_state = HSH_SW_SRCH; // R2 R4
              end
            end
          end
        end
        HSH_SW_SRCH: begin
          // Positive search for the switch falling edge
          if (sw_fall) begin
            next_state    = HSH_IDX_SRCH; // R3 R6
            next_move_dir = index_dir(method); // R1
            next_velocity = home_position_search_velocity_in; // R8
            log_wr        = 1'b1;
          end
        end
        HSH_OT_SRCH: begin
          if (ot) begin
            next_state    = HSH_REV_SRCH; // R5
            next_move_dir = `HSH_DIR_NEG;
            log_wr        = 1'b1;
          end
        end
        HSH_REV_SRCH: begin
          // Negative search for the switch rising edge
          if (sw_rise) begin
            next_state    = HSH_IDX_SRCH; // R7
            next_move_dir = index_dir(method);
            next_velocity = home_position_search_velocity_in; // R8
            log_wr        = 1'b1;
          end
        end
        HSH_IDX_SRCH: begin
          if (idx_rise) begin
            next_state      = HSH_DONE; // R9
            next_move_en    = 1'b0;
            next_home_latch = 1'b1; // R3 R6 R7
            next_home_done  = 1'b1;
            next_busy       = 1'b0;
            log_wr          = 1'b1;
          end
        end
        HSH_DONE: begin
          next_state = HSH_IDLE;
        end
        HSH_FAULT: begin
          next_state = HSH_IDLE;
        end
        default: begin
          next_state   = HSH_IDLE;
          next_move_en = 1'b0;
          next_busy    = 1'b0;
        end
      endcase
    end
    if (log_wr) begin
      next_log_ptr = log_ptr + 1'b1;
    end
  end

  // Register the sequencer
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state          <= HSH_IDLE;
      method         <= 4'h0;
      move_en_out    <= 1'b0;
      move_dir_out   <= `HSH_DIR_POS;
      velocity_out   <= '0;
      busy_out       <= 1'b0;
      home_done_out  <= 1'b0;
      home_latch_out <= 1'b0;
      fault_out      <= 1'b0;
      log_ptr        <= '0;
    end else begin
      state          <= next_state;
      method         <= next_method;
      move_en_out    <= next_move_en;
      move_dir_out   <= next_move_dir;
      velocity_out   <= next_velocity;
      busy_out       <= next_busy;
      home_done_out  <= next_home_done;
      home_latch_out <= next_home_latch;
      fault_out      <= next_fault;
      log_ptr        <= next_log_ptr;
    end
  end

  // Phase log records each search state as it is left on its exit event; start and abort write nothing
  hsh_phase_log u_log (
    .ref_clk_in  (ref_clk_in),
    .wr_en_in    (log_wr),
    .wr_addr_in  (log_ptr),
    .wr_data_in  (state),
    .rd_addr_in  (log_addr_in),
    .rd_data_out (log_data_out)
  );
endmodule
`default_nettype wire

// ==== testbench/hsh_axis_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Axis: one count a cycle, index every 32 counts, switch 40..46, limit from 80
module hsh_axis_model (
  input  wire logic               ref_clk_in,
  input  wire logic               move_en_in,
  input  wire logic               move_dir_in,
  input  wire logic               load_in,
  input  wire logic signed [15:0] load_pos_in,
  output logic                    home_switch_out,
  output logic                    overtravel_out,
  output logic                    index_out,
  output logic signed [15:0]      last_index_out
);
  logic signed [15:0] pos = 16'sh0;
  // Motion and index capture
  always @(posedge ref_clk_in) begin
    if (load_in)
      pos <= load_pos_in;
    else if (move_en_in)
      pos <= move_dir_in ? pos + 16'sh1 : pos - 16'sh1;
    if (index_out && !load_in)
      last_index_out <= pos;
  end
  // Sensor pins from position
  assign home_switch_out = (pos >= 16'sd40) && (pos <= 16'sd46);
  assign overtravel_out  = pos >= 16'sd80;
  assign index_out       = pos[4:0] == 5'h00;
endmodule
`default_nettype wire

// ==== testbench/hsh_homing_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "hsh_params.svh"
// Port checker of the homing sequencer
module hsh_homing_chk (
  input wire logic                  ref_clk_in,
  input wire logic                  rst_in,
  input wire logic                  start_in,
  input wire logic                  third_case_in,
  input wire logic                  abort_in,
  input wire logic [3:0]            homing_method_select_in,
  input wire logic [`HSH_VEL_W-1:0] near_home_search_velocity_in,
  input wire logic [`HSH_VEL_W-1:0] home_position_search_velocity_in,
  input wire logic                  home_switch_input_in,
  input wire logic                  move_en_out,
  input wire logic                  move_dir_out,
  input wire logic [`HSH_VEL_W-1:0] velocity_out,
  input wire logic                  busy_out,
  input wire logic                  home_done_out,
  input wire logic                  home_latch_out,
  input wire logic                  fault_out
);
  logic [3:0] meth;
  logic       ot_path;
  logic [1:0] sw_pipe;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Two-stage copy of the switch pin, as the sequencer sees it
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sw_pipe <= 2'h0;
    end else begin
      sw_pipe <= {sw_pipe[0], home_switch_input_in};
    end
  end
  // Method and start case taken at an accepted start
  always_ff @(posedge ref_clk_in) begin
    if (start_in && !busy_out) begin
      meth    <= homing_method_select_in;
      ot_path <= third_case_in && !sw_pipe[1];
    end
  end
  a_start_moves: assert property (
    start_in && !busy_out && !abort_in && homing_method_select_in inside
    {`HSH_METHOD_LEFT_FALL, `HSH_METHOD_RIGHT_FALL} |=> move_en_out && busy_out && move_dir_out
    && velocity_out == $past(near_home_search_velocity_in)) else $error("bad search start");
  a_bad_method: assert property (
    start_in && !busy_out && !abort_in && !(homing_method_select_in inside
    {`HSH_METHOD_LEFT_FALL, `HSH_METHOD_RIGHT_FALL}) |=> fault_out && !move_en_out)
    else $error("invalid method not refused");
  a_index_phase: assert property (
    move_en_out && $past(move_en_out) && $changed(velocity_out) |->
    velocity_out == home_position_search_velocity_in
    && move_dir_out == (meth == `HSH_METHOD_RIGHT_FALL)) else $error("bad index phase");
  a_ot_reverse: assert property (
    move_en_out && $past(move_en_out) && $fell(move_dir_out) && $stable(velocity_out) |->
    ot_path && velocity_out == near_home_search_velocity_in) else $error("bad reversal");
  a_right_pos: assert property (
    busy_out && meth == `HSH_METHOD_RIGHT_FALL && !ot_path |-> move_dir_out)
    else $error("right mode moved negative");
  a_latch_stop: assert property (
    home_latch_out |-> home_done_out && !move_en_out && !busy_out ##1 !home_latch_out)
    else $error("latch without stop");
  a_done_holds: assert property (
    home_done_out && !start_in && !abort_in |=> home_done_out) else $error("done dropped");
  a_abort_stop: assert property (
    abort_in |=> !move_en_out && !busy_out) else $error("abort did not stop");
  c_latch: cover property (home_latch_out);
  c_reverse: cover property (move_en_out && $fell(move_dir_out) && $stable(velocity_out));
  c_fault: cover property ($rose(fault_out));
endmodule
bind hsh_homing hsh_homing_chk u_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .start_in(start_in), .third_case_in(third_case_in), .abort_in(abort_in),
  .homing_method_select_in(homing_method_select_in),
  .near_home_search_velocity_in(near_home_search_velocity_in),
  .home_position_search_velocity_in(home_position_search_velocity_in),
  .home_switch_input_in(home_switch_input_in), .move_en_out(move_en_out),
  .move_dir_out(move_dir_out), .velocity_out(velocity_out), .busy_out(busy_out),
  .home_done_out(home_done_out), .home_latch_out(home_latch_out), .fault_out(fault_out));
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic ref_clk_in = 0, rst_in = 1, start_in = 0, third = 0, abort = 0, load = 0;
  logic [3:0] method = 0, m;
  logic [15:0] near_v = 0, home_v = 0, vel;
  logic [2:0] log_addr = 0, log_data;
  logic signed [15:0] load_pos = 0, last_idx;
  logic sw, ot, idx, mv, dir, busy, done, latch, fault;
  int failures = 0, n_compared = 0, seed = 2, cycles = 0;
  logic [15:0] exp_q[$];
  always #50 ref_clk_in = ~ref_clk_in;
  hsh_homing uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .start_in(start_in),
    .homing_method_select_in(method), .third_case_in(third), .near_home_search_velocity_in(near_v),
    .home_position_search_velocity_in(home_v), .home_switch_input_in(sw),
    .positive_overtravel_input_in(ot), .index_pulse_in(idx), .abort_in(abort),
    .log_addr_in(log_addr), .move_en_out(mv), .move_dir_out(dir), .velocity_out(vel),
    .busy_out(busy), .home_done_out(done), .home_latch_out(latch), .fault_out(fault),
    .log_data_out(log_data));
  hsh_axis_model axis (.ref_clk_in(ref_clk_in), .move_en_in(mv), .move_dir_in(dir),
    .load_in(load), .load_pos_in(load_pos), .home_switch_out(sw), .overtravel_out(ot),
    .index_out(idx), .last_index_out(last_idx));
  // Compare and count
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task tick();
    @(posedge ref_clk_in);
    #1;
  endtask
  // One homing run from a start position; abort after ab cycles when ab is nonzero
  task run(input logic [3:0] mt, input logic tc, input logic signed [15:0] p,
           input logic [15:0] e, input int ab);
    int k;
    tick();
    load = 1;
    load_pos = p;
    method = mt;
    third = tc;
    near_v = 16'($random(seed));
    home_v = near_v ^ 16'h8000;
    log_addr = 3'($random(seed));
    tick();
    load = 0;
    repeat (4) tick();
    start_in = 1;
    if ((mt == 4'h9 || mt == 4'hA) && ab == 0)
      exp_q.push_back(e);
    tick();
    start_in = 0;
    for (k = 0; k < ab; k++)
      tick();
    abort = ab != 0;
    tick();
    abort = 0;
    for (k = 0; busy === 1'b1 && k < 2000; k++)
      tick();
    check({15'h0, mv}, 16'h0);
    check({15'h0, busy}, 16'h0);
    if (ab != 0)
      check({15'h0, done}, 16'h0);
    else if (mt == 4'h9 || mt == 4'hA) begin
      check({15'h0, done}, 16'h1);
      // Last logged phase before done is the index search
      log_addr = tc ? 3'h2 : 3'h1;
      tick();
      check({13'h0, log_data}, {13'h0, hsh_pkg::HSH_IDX_SRCH});
    end else
      check({15'h0, fault}, 16'h1);
  endtask
  // Home index seen by the axis at each latch pulse
  always @(negedge ref_clk_in) begin
    if (latch === 1'b1 && exp_q.size() == 0)
      check(16'h1, 16'h0);
    else if (latch === 1'b1)
      check(last_idx, exp_q.pop_front());
  end
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk_in);
    #1 rst_in = 0;
    for (int i = 0; i < 6; i++)
      run(i[0] ? 4'hA : 4'h9, i > 3, i < 2 ? 16'sd20 : (i < 4 ? 16'sd43 : 16'sd50),
          i[0] ? 16'h0040 : 16'h0020, 0);
    run(4'hA, 0, 16'sd20, 16'h0, 5);
    repeat (3) begin
      m = 4'($random(seed));
      if (m == 4'h9 || m == 4'hA)
        m = 4'h3;
      run(m, 0, 16'sd20, 16'h0, 0);
    end
    run(4'h9, 0, 16'sd43, 16'h0020, 0);
    check(16'(exp_q.size()), 16'h0);
    summarize();
  end
endmodule
`default_nettype wire
